// ### rtl/bbc_ctrl_port.sv
// Digital control port of a buck-boost converter: I2C slave, registers, mode logic.
// Assumes open-drain pads outside; SCL clocks the link side, i_clk_sys the rest.
//
// Behaviour
// (RQ1) Discharge while enable pin low or bit clear.
// (RQ2) On mode needs supply good and pin high.
// (RQ3) Off mode on undervoltage or pin low.
// (RQ4) Slave only, up to fast-mode plus.
// (RQ5) Only 7-bit addresses, no general call.
// (RQ6) Answer only to address 1110101.
// (RQ7) Master sends stop after pull-up power.
// (RQ8) Start is SDA fall while SCL high.
// (RQ9) Receiver acknowledges every byte, repeats freely. Here a byte after the write data byte gets no acknowledge.
// (RQ10) Stop is SDA rise; release, await start.
// (RQ11) Unmapped register reads return zero.
// (RQ12) Write: start, address, register, data byte.
// (RQ13) Acknowledge holds SDA low one pulse.
// (RQ14) Commit write at acknowledge falling edge.
// (RQ15) Control resets zero, or enable-only variant.
// (RQ16) Control bits 7 and 4 stored only.
// (RQ17) Bit 6 selects output voltage range.
// (RQ18) Bit 5 enables the converter.
// (RQ19) Bit 3 forces fixed-frequency switching.
// (RQ20) Bit 2 enables ramped switching.
// (RQ21) Bits 1:0 select ramp rate.
// (RQ22) Fault flags set, clear on read after end.
// (RQ23) Preset select pin picks preset a or b.
// (RQ24) Presets reset 0x3c and 0x42, bit7 zero.
// (RQ25) Identity register read-only, maker and revisions.
// (RQ26) Read: address write, repeated start, read byte.
// (RQ27) Unmapped or read-only writes acked, ignored.
`timescale 1ns/1ns
`include "bbc_consts.svh"
module bbc_ctrl_port #(
  parameter bit       FIXED_VARIANT = 1'b0,
  parameter bit [3:0] MAKER_CODE    = 4'h9  // Arbitrary value.
) (
  // System clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // I2C pins, open drain
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Converter pins and analog status
  input  wire logic       i_enable_pin,
  input  wire logic       i_supply_ok,
  input  wire logic       i_preset_select_pin,
  input  wire logic       i_thermal_event,
  input  wire logic       i_power_not_good_event,
  // Converter controls
  output logic            o_on_mode,
  output logic            o_converter_run,
  output logic            o_output_discharge,
  output logic            o_high_range,
  output logic            o_forced_fixed_frequency,
  output logic            o_ramped_switching,
  output logic [1:0]      o_ramp_rate,
  output logic [6:0]      o_setpoint
);

  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n) rst_sync_r <= 2'h0;
    else          rst_sync_r <= {rst_sync_r[0], 1'b1};
  assign rst_n = rst_sync_r[1];

  // Link domain, clocked by SCL. SCL stands still between frames, so a start is
  // caught on the SDA fall and handed over by the SCL fall that follows it, and
  // a stop releases the data driver asynchronously.
  logic start_r;
  logic start_hold_r;
  logic start_clr_n;
  logic stop_r;
  logic stop_clr_n;
  logic link_clr_n;
  assign start_clr_n = i_rst_n & ~start_hold_r;
  assign stop_clr_n  = i_rst_n & ~start_r;
  assign link_clr_n  = i_rst_n & ~stop_r;

  always_ff @(negedge i_sda or negedge start_clr_n)
    if (!start_clr_n)
    begin
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= i_scl; // RQ8
    end

  always_ff @(negedge i_scl or negedge i_rst_n)
    if (!i_rst_n)
    begin
      start_hold_r <= 1'b0;
    end
    else
    begin
      start_hold_r <= start_r;
    end

  always_ff @(posedge i_sda or negedge stop_clr_n)
    if (!stop_clr_n)
    begin
      stop_r <= 1'b0;
    end
    else
    begin
      stop_r <= i_scl; // RQ10
    end

  bbc_pkg::bbc_phase_t phase_r;
  logic [3:0]          bit_cnt_r;
  logic [7:0]          shift_r;
  logic [7:0]          reg_ptr_r;
  logic                wr_pend_r;
  logic                ack_slot_r;
  logic                wr_tgl_r;
  logic [7:0]          wr_addr_r;
  logic [7:0]          wr_data_r;
  logic                rd_tgl_r;
  logic [7:0]          rd_byte_r;
  logic [7:0]          rd_shift_r;

  // Bit counter and receive shifter. The block only answers; it never drives SCL.
  always_ff @(posedge i_scl or negedge i_rst_n)
    if (!i_rst_n)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
    end
    else if (start_hold_r)
    begin
      bit_cnt_r <= 4'h1;
      shift_r   <= {7'h00, i_sda};
    end
    else if (phase_r == bbc_pkg::BBC_IDLE || phase_r == bbc_pkg::BBC_SKIP)
    begin
      bit_cnt_r <= 4'h0; // RQ4
    end
    else if (bit_cnt_r == 4'h8)
    begin
      bit_cnt_r <= 4'h0; // RQ9
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= {shift_r[6:0], i_sda};
    end

  // Protocol phase, decided on the SCL rise of each acknowledge bit.
  always_ff @(posedge i_scl or negedge i_rst_n)
    if (!i_rst_n)
    begin
      phase_r   <= bbc_pkg::BBC_IDLE;
      reg_ptr_r <= 8'h00;
      wr_pend_r <= 1'b0;
    end
    else if (start_hold_r)
    begin
      phase_r   <= bbc_pkg::BBC_ADDR;
      wr_pend_r <= 1'b0;
    end
    else if (bit_cnt_r == 4'h8)
    begin
      case (phase_r)
        bbc_pkg::BBC_ADDR:
          if (shift_r[7:1] == `BBC_SLAVE_ADDR) // RQ5 RQ6
          begin
            phase_r <= shift_r[0] ? bbc_pkg::BBC_RDATA : bbc_pkg::BBC_REG;
          end
          else
          begin
            phase_r <= bbc_pkg::BBC_SKIP;
          end
        bbc_pkg::BBC_REG:
        begin
          reg_ptr_r <= shift_r;
          phase_r   <= bbc_pkg::BBC_WDATA;
        end
        bbc_pkg::BBC_WDATA:
        begin
          wr_pend_r <= 1'b1;
          phase_r   <= bbc_pkg::BBC_SKIP;
        end
        bbc_pkg::BBC_RDATA:
        begin
          phase_r <= i_sda ? bbc_pkg::BBC_SKIP : bbc_pkg::BBC_RDATA; // RQ26
        end
        default:
        begin
          phase_r <= phase_r;
        end
      endcase
    end

  // Data driver on the SCL fall: acknowledge, then read data MSB first.
  always_ff @(negedge i_scl or negedge link_clr_n)
    if (!link_clr_n)
    begin
      o_sda_oe   <= 1'b0; // RQ10
      ack_slot_r <= 1'b0;
      rd_shift_r <= 8'h00;
    end
    else if (start_r)
    begin
      o_sda_oe   <= 1'b0;
      ack_slot_r <= 1'b0;
    end
    else if (bit_cnt_r == 4'h8 && !ack_slot_r)
    begin
      ack_slot_r <= 1'b1;
      o_sda_oe   <= (phase_r == bbc_pkg::BBC_ADDR && shift_r[7:1] == `BBC_SLAVE_ADDR)
                 || phase_r == bbc_pkg::BBC_REG || phase_r == bbc_pkg::BBC_WDATA; // RQ13
    end
    else if (ack_slot_r)
    begin
      ack_slot_r <= 1'b0;
      if (phase_r == bbc_pkg::BBC_RDATA)
      begin
        rd_shift_r <= rd_byte_r;
        o_sda_oe   <= ~rd_byte_r[7];
      end
      else
      begin
        o_sda_oe <= 1'b0;
      end
    end
    else if (phase_r == bbc_pkg::BBC_RDATA && bit_cnt_r != 4'h0)
    begin
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      o_sda_oe   <= ~rd_shift_r[6];
    end
    else
    begin
      o_sda_oe <= 1'b0;
    end

  // Write commit at the fall ending the data acknowledge. Address and data stand
  // until the next write, so only the toggle needs synchronising.
  always_ff @(negedge i_scl or negedge i_rst_n)
    if (!i_rst_n)
    begin
      wr_tgl_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end
    else if (ack_slot_r && wr_pend_r)
    begin
      wr_addr_r <= reg_ptr_r;
      wr_data_r <= shift_r;
      wr_tgl_r  <= ~wr_tgl_r; // RQ14
    end

  // Each byte handed out is announced, so that a fault read can clear flags.
  always_ff @(negedge i_scl or negedge i_rst_n)
    if (!i_rst_n)
    begin
      rd_tgl_r <= 1'b0;
    end
    else if (ack_slot_r && phase_r == bbc_pkg::BBC_RDATA)
    begin
      rd_tgl_r <= ~rd_tgl_r;
    end

  // The data pin only ever pulls low; the enable does the signalling.
  always_ff @(negedge i_scl or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_sda <= 1'b0;
    end
    else
    begin
      o_sda <= 1'b0;
    end

  // System domain.
  logic [1:0] wr_sync_r;
  logic       wr_seen_r;
  logic [1:0] rd_sync_r;
  logic       rd_seen_r;
  logic [1:0] en_sync_r;
  logic [1:0] uv_sync_r;
  logic [1:0] sel_sync_r;
  logic [1:0] tsd_sync_r;
  logic [1:0] png_sync_r;
  always_ff @(posedge i_clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wr_sync_r  <= 2'h0;
      rd_sync_r  <= 2'h0;
      en_sync_r  <= 2'h0;
      uv_sync_r  <= 2'h0;
      sel_sync_r <= 2'h0;
      tsd_sync_r <= 2'h0;
      png_sync_r <= 2'h0;
    end
    else
    begin
      wr_sync_r  <= {wr_sync_r[0], wr_tgl_r};
      rd_sync_r  <= {rd_sync_r[0], rd_tgl_r};
      en_sync_r  <= {en_sync_r[0], i_enable_pin};
      uv_sync_r  <= {uv_sync_r[0], i_supply_ok};
      sel_sync_r <= {sel_sync_r[0], i_preset_select_pin};
      tsd_sync_r <= {tsd_sync_r[0], i_thermal_event};
      png_sync_r <= {png_sync_r[0], i_power_not_good_event};
    end

  logic wr_pulse;
  logic rd_pulse;
  assign wr_pulse = wr_sync_r[1] ^ wr_seen_r;
  assign rd_pulse = rd_sync_r[1] ^ rd_seen_r;

  logic [7:0] control_settings_r;
  logic [6:0] voltage_preset_a_r;
  logic [6:0] voltage_preset_b_r;
  always_ff @(posedge i_clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wr_seen_r          <= 1'b0;
      control_settings_r <= FIXED_VARIANT ? `BBC_CTL_RST_FIXED : `BBC_CTL_RST_PROG; // RQ15
      voltage_preset_a_r <= `BBC_PRESET_A_RST; // RQ24
      voltage_preset_b_r <= `BBC_PRESET_B_RST; // RQ24
    end
    else
    begin
      wr_seen_r <= wr_sync_r[1];
      if (wr_pulse)
        case (wr_addr_r) // RQ27
          `BBC_OFS_CONTROL:  control_settings_r <= wr_data_r; // RQ16
          `BBC_OFS_PRESET_A: voltage_preset_a_r <= wr_data_r[6:0];
          `BBC_OFS_PRESET_B: voltage_preset_b_r <= wr_data_r[6:0];
          default:           ;
        endcase
    end

  // Flags: an event in the clearing cycle keeps its flag set.
  logic thermal_shutdown_flag_r;
  logic power_not_good_flag_r;
  logic rd_fault;
  assign rd_fault = rd_pulse && reg_ptr_r == `BBC_OFS_FAULT;
  always_ff @(posedge i_clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      rd_seen_r               <= 1'b0;
      thermal_shutdown_flag_r <= 1'b0;
      power_not_good_flag_r   <= 1'b0;
    end
    else
    begin
      rd_seen_r <= rd_sync_r[1];
      thermal_shutdown_flag_r <= tsd_sync_r[1] | (thermal_shutdown_flag_r & ~rd_fault); // RQ22
      power_not_good_flag_r   <= png_sync_r[1] | (power_not_good_flag_r & ~rd_fault); // RQ22
    end

  // Read mux; the link samples it one byte later, so it is stable by then.
  always_comb
    case (reg_ptr_r)
      `BBC_OFS_CONTROL:  rd_byte_r = control_settings_r;
      `BBC_OFS_FAULT:    rd_byte_r = {6'h00, thermal_shutdown_flag_r, power_not_good_flag_r};
      `BBC_OFS_IDENT:    rd_byte_r = {MAKER_CODE, `BBC_MAJOR_REV, `BBC_MINOR_REV}; // RQ25
      `BBC_OFS_PRESET_A: rd_byte_r = {1'b0, voltage_preset_a_r};
      `BBC_OFS_PRESET_B: rd_byte_r = {1'b0, voltage_preset_b_r};
      default:           rd_byte_r = 8'h00; // RQ11
    endcase

  always_ff @(posedge i_clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      o_on_mode                <= 1'b0;
      o_converter_run          <= 1'b0;
      o_output_discharge       <= 1'b1;
      o_high_range             <= 1'b0;
      o_forced_fixed_frequency <= 1'b0;
      o_ramped_switching       <= 1'b0;
      o_ramp_rate              <= 2'h0;
      o_setpoint               <= `BBC_PRESET_A_RST;
    end
    else
    begin
      o_on_mode          <= uv_sync_r[1] & en_sync_r[1]; // RQ2 RQ3
      o_converter_run    <= uv_sync_r[1] & en_sync_r[1] & control_settings_r[`BBC_BIT_ENABLE]; // RQ18
      o_output_discharge <= ~en_sync_r[1] | ~control_settings_r[`BBC_BIT_ENABLE]; // RQ1
      o_high_range             <= control_settings_r[`BBC_BIT_RANGE]; // RQ17
      o_forced_fixed_frequency <= control_settings_r[`BBC_BIT_FORCED]; // RQ19
      o_ramped_switching       <= control_settings_r[`BBC_BIT_RAMPED]; // RQ20
      o_ramp_rate <= control_settings_r[`BBC_SLEW_HI:`BBC_SLEW_LO]; // RQ21
      o_setpoint  <= sel_sync_r[1] ? voltage_preset_b_r : voltage_preset_a_r; // RQ23
    end

endmodule

// ### rtl/bbc_consts.svh
// Constants of the converter control port: offsets, fields, reset values.
// Assumes inclusion by bare name from the design module.
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
`define BBC_SLAVE_ADDR      7'h75
`define BBC_OFS_CONTROL     8'h01
`define BBC_OFS_FAULT       8'h02
`define BBC_OFS_IDENT       8'h03
`define BBC_OFS_PRESET_A    8'h04
`define BBC_OFS_PRESET_B    8'h05
`define BBC_CTL_RST_PROG    8'h00
`define BBC_CTL_RST_FIXED   8'h20
`define BBC_PRESET_A_RST    7'h3c
`define BBC_PRESET_B_RST    7'h42
`define BBC_BIT_RANGE       6
`define BBC_BIT_ENABLE      5
`define BBC_BIT_FORCED      3
`define BBC_BIT_RAMPED      2
`define BBC_SLEW_HI         1
`define BBC_SLEW_LO         0
`define BBC_BIT_THERMAL     1
`define BBC_BIT_PNG         0
`define BBC_MAJOR_REV       2'h1
`define BBC_MINOR_REV       2'h0
`endif

// ### rtl/bbc_pkg.sv
// Types shared by the converter control port.
// Assumes the constants header sits beside it.
package bbc_pkg;
  typedef enum logic [2:0] {
    BBC_IDLE,
    BBC_ADDR,
    BBC_REG,
    BBC_WDATA,
    BBC_RDATA,
    BBC_SKIP
  } bbc_phase_t;
endpackage

// ### tb/bbc_ctrl_port_monitor.sv
// Checker for the converter control port, bound to its top module.
// Assumes the top module's port names and a single system clock domain.
`timescale 1ns/1ns
module bbc_ctrl_port_monitor (
  // Clock, reset and link pins
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_oe,
  // Converter pins and controls
  input wire logic       i_enable_pin,
  input wire logic       i_supply_ok,
  input wire logic       i_preset_select_pin,
  input wire logic       o_on_mode,
  input wire logic       o_converter_run,
  input wire logic       o_output_discharge,
  input wire logic [6:0] o_setpoint
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  a_discharge_pin_low: assert property ((!i_enable_pin)[*6] |-> o_output_discharge)
    else $error("discharge missing while enable pin low");
  a_idle_discharge: assert property (o_on_mode && !o_converter_run |-> o_output_discharge)
    else $error("discharge missing while converter stopped");
  a_on_mode_entry: assert property ((i_supply_ok && i_enable_pin)[*6] |-> o_on_mode)
    else $error("on mode not entered");
  a_supply_low_off: assert property ((!i_supply_ok)[*6] |-> !o_on_mode)
    else $error("on mode held under low supply");
  a_run_consistent: assert property (o_converter_run |-> o_on_mode && !o_output_discharge)
    else $error("converter runs outside on mode");
  a_ack_on_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data driver changed while clock high");
  a_stop_release: assert property (i_scl && $rose(i_sda) |=> (!o_sda_oe)[*4])
    else $error("data line held after stop");
  a_setpoint_quiet: assert property (($stable(i_preset_select_pin) && i_scl)[*8]
    |-> $stable(o_setpoint))
    else $error("setpoint moved on an idle bus");
endmodule
bind bbc_ctrl_port bbc_ctrl_port_monitor u_bbc_ctrl_port_monitor (.i_clk_sys, .i_rst_n,
  .i_scl, .i_sda, .o_sda_oe, .i_enable_pin, .i_supply_ok, .i_preset_select_pin, .o_on_mode,
  .o_converter_run, .o_output_discharge, .o_setpoint);

// ### tb/bbc_mst.sv
// Behavioural I2C bus master with an 80 ns bit clock.
// Assumes the bench resolves the pulled-up data wire from both enables.
`timescale 1ns/1ns
module bbc_mst (
  // Bus pins
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  localparam int H = 40;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // The clock stands still between frames, as a real master leaves it.
  task automatic start();
    #3 o_sda_low = 1'b0;
    #H o_scl = 1'b1;
    #H o_sda_low = 1'b1;
    #H o_scl = 1'b0;
  endtask
  task automatic stop();
    if (o_scl)
    begin
      #3 o_scl = 1'b0;
    end
    #3 o_sda_low = 1'b1;
    #H o_scl = 1'b1;
    #H o_sda_low = 1'b0;
    #H;
  endtask
  task automatic bit1(input logic b, output logic s);
    o_sda_low = !b;
    #H o_scl = 1'b1;
    s = i_sda;
    #H o_scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(d[i], s);
    bit1(1'b1, s);
    ack = (s === 1'b0);
  endtask
  task automatic rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit1(1'b1, s);
      d[i] = s;
    end
    bit1(1'b1, s);
  endtask
endmodule

// ### tb/bbc_ctrl_port_tb.sv
// Self-checking bench for the converter control port.
// Assumes the master model drives the link; pins change on clock edges.
`timescale 1ns/1ns
module bbc_ctrl_port_tb;
  localparam bit [3:0] MK = 4'h6; // Arbitrary value.
  logic       clk = 0, rst_n = 0, en = 0, sup = 0, sel = 0, th = 0, png = 0;
  logic       scl, m_low, sda, osda, oe, on, run, dis, hi, ff, rp, k;
  logic [1:0] rate;
  logic [6:0] sp;
  logic [7:0] v;
  int         err_total = 0, total_checks = 0;
  assign sda = !(m_low || (oe && !osda));
  bbc_mst u_bbc_mst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
  bbc_ctrl_port #(.FIXED_VARIANT(1'b0), .MAKER_CODE(MK)) u_bbc_ctrl_port (.i_clk_sys(clk),
    .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(osda), .o_sda_oe(oe),
    .i_enable_pin(en), .i_supply_ok(sup), .i_preset_select_pin(sel), .i_thermal_event(th),
    .i_power_not_good_event(png), .o_on_mode(on), .o_converter_run(run),
    .o_output_discharge(dis), .o_high_range(hi), .o_forced_fixed_frequency(ff),
    .o_ramped_switching(rp), .o_ramp_rate(rate), .o_setpoint(sp));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [2:0] q;
    u_bbc_mst.start();
    u_bbc_mst.tx(8'hea, q[2]);
    u_bbc_mst.tx(a, q[1]);
    u_bbc_mst.tx(d, q[0]);
    u_bbc_mst.stop();
    chk({5'h0, q}, 8'h07);
    repeat (6) @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [2:0] q;
    logic [7:0] d;
    u_bbc_mst.start();
    u_bbc_mst.tx(8'hea, q[2]);
    u_bbc_mst.tx(a, q[1]);
    u_bbc_mst.start();
    u_bbc_mst.tx(8'heb, q[0]);
    u_bbc_mst.rx(d);
    u_bbc_mst.stop();
    chk({5'h0, q}, 8'h07);
    chk(d, e);
    repeat (4) @(posedge clk);
  endtask
  task automatic probe(input logic [7:0] b);
    u_bbc_mst.start();
    u_bbc_mst.tx(b, k);
    u_bbc_mst.stop();
    chk({7'h0, k}, 8'h00);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    u_bbc_mst.stop();
    rc(8'h01, 8'h00);
    rc(8'h02, 8'h00);
    rc(8'h03, {MK, 4'h4});
    rc(8'h04, 8'h3c);
    rc(8'h05, 8'h42);
    rc(8'h00, 8'h00);
    rc(8'h06, 8'h00);
    $display("test reset values done");
    en <= 1'b1;
    sup <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      v = {i[1:0], 1'b1, i[0], i[1:0], i[1:0]};
      wr(8'h01, v);
      rc(8'h01, v);
      chk({1'b0, hi, ff, rp, rate, run, dis}, {1'b0, v[6], v[3:0], 2'b10});
    end
    $display("test control fields done");
    for (int j = 0; j < 8; j++)
    begin
      if (j[1:0] == 2'b00) wr(8'h01, {2'h0, j[2], 5'h0});
      en <= j[0];
      sup <= j[1];
      repeat (8) @(posedge clk);
      chk({5'h0, on, run, dis}, {5'h0, j[0] & j[1], j[0] & j[1] & j[2], !(j[0] & j[2])});
    end
    $display("test modes done");
    wr(8'h04, 8'hff);
    wr(8'h05, 8'h11);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'hff);
    wr(8'h07, 8'h55);
    rc(8'h04, 8'h7f);
    rc(8'h03, {MK, 4'h4});
    rc(8'h02, 8'h00);
    rc(8'h01, 8'h20);
    chk({1'b0, sp}, 8'h7f);
    sel <= 1'b1;
    repeat (8) @(posedge clk);
    chk({1'b0, sp}, 8'h11);
    $display("test presets done");
    probe(8'he8);
    probe(8'h00);
    probe(8'hf0);
    $display("test addressing done");
    th <= 1'b1;
    png <= 1'b1;
    repeat (8) @(posedge clk);
    th <= 1'b0;
    repeat (8) @(posedge clk);
    rc(8'h02, 8'h03);
    rc(8'h02, 8'h01);
    png <= 1'b0;
    repeat (8) @(posedge clk);
    rc(8'h02, 8'h01);
    rc(8'h02, 8'h00);
    $display("test fault flags done");
    summarize();
  end
  // A hang still reaches the verdict, counted as a failure.
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule
